/* File: shared/eep_pkg.sv */
// Constants and types shared by the serial memory slave
// Contract
// - Power-on reset restarts everything into standby
// - Sample SDA on SCL rise, drive after fall
// - SDA change while SCL high is START/STOP
// - START detect; ignore traffic before START
// - STOP detect; write STOP starts programming
// - Address is type code, selects, direction
// - Acknowledge matching address and written bytes
// - Read: eight bits, release, continue on ACK
// - Byte write acknowledges four bytes then programs
// - Busy programming withholds address acknowledge
// - Address word: skip MSB, page, offset
// - Page write wraps offset inside page
// - Strobe protect before first data byte
// - Protect input low means no effect
// - Memory starts erased to all ones
// - Counter holds next location, wraps at end
// - Read address acknowledged, then counter byte
// - Dummy write loads counter, programs nothing
// - Sequential read increments and wraps counter
package eep_pkg;
  localparam int          ADDR_W         = 15;
  localparam int          OFS_W          = 6;
  localparam int          PAGE_BYTES     = 64;
  // Device-type code of the slave address; value is arbitrary
  localparam logic [3:0]  DEV_TYPE_CODE  = 4'h6;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int          CLOCK_MHZ      = 200;
  localparam int          WRITE_TIME_US  = 5000;
  localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLOCK_MHZ;
  localparam int          FILTER_CYCLES  = 4;
  localparam logic [3:0]  BIT_ACK        = 4'h8;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_AHI  = 6'h04,
    ST_ALO  = 6'h08,
    ST_WDAT = 6'h10,
    ST_RDAT = 6'h20
  } eep_phase_type;
endpackage : eep_pkg

/* File: shared/eep_fifo_if.sv */
// Interface between the write path and the page buffer FIFO
`timescale 1ns/10ps
interface eep_fifo_if #(parameter int WIDTH = 14);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport src  (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface : eep_fifo_if

/* File: logic/eep_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module eep_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic CLOCK_I,
  input  wire logic RST_I,
  input  wire logic flush_i,
  // Streams
  eep_fifo_if.fifo  port
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } eep_fifo_state_type;
  eep_fifo_state_type st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push, pop;

  assign port.in_ready  = (st.cnt != (PW+1)'(DEPTH));
  assign port.out_valid = (st.cnt != '0);
  assign port.out_data  = mem[st.rp];
  assign push = port.in_valid & port.in_ready;
  assign pop  = port.out_valid & port.out_ready;

  always_comb begin
    next_st = st;
    if (push) next_st.wp = (st.wp == PW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    if (pop)  next_st.rp = (st.rp == PW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush_i) next_st = '0;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) st <= '0;
    else st <= next_st;
    if (push) mem[st.wp] <= port.in_data;
  end
endmodule : eep_fifo

/* File: logic/eep_slave.sv */
// Two-wire serial memory slave with page buffer and write timer
`timescale 1ns/10ps
module eep_slave
  import eep_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES,
  parameter int FIFO_D    = 8
) (
  // Clock and reset
  input  wire logic CLOCK_I,
  input  wire logic RST_I,
  // Serial bus
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_N_O,
  // Straps
  input  wire logic SELECT_PIN_0_I,
  input  wire logic SELECT_PIN_1_I,
  input  wire logic SELECT_PIN_2_I,
  input  wire logic WP_I,
  // Status
  output logic      BUSY_O
);
  localparam int FW = OFS_W + 8;

  typedef struct packed {
    logic [2:0]          scl_s;
    logic [2:0]          sda_s;
    logic [2:0]          wp_s;
    logic [2:0]          sel0_s;
    logic [2:0]          sel1_s;
    logic [2:0]          sel2_s;
    logic                scl_f;
    logic                sda_f;
    logic [2:0]          scl_cnt;
    logic [2:0]          sda_cnt;
    eep_phase_type       phase;
    logic [3:0]          bitn;
    logic [7:0]          shreg;
    logic                rw;
    logic                acking;
    logic                nack;
    logic                wp_lat;
    logic                wr_pend;
    logic [ADDR_W-1:0]   acnt;
    logic [ADDR_W-1:0]   page_base;
    logic                busy;
    logic                drain;
    logic [31:0]         timer;
    logic                sda_drv;
  } eep_state_type;

  eep_state_type st, next_st;
  logic [7:0]        mem [2**ADDR_W];
  eep_fifo_if #(.WIDTH(FW)) fif ();
  logic              scl_rise, scl_fall, start_c, stop_c, dev_match;
  logic [7:0]        rd_byte;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic              flush;

  // Glitch filter: follow a synced input only after it stays put
  function automatic logic [3:0] filt(input logic f, input logic [2:0] c,
                                      input logic a, input logic b);
    logic [3:0] r;
    r = {f, c};
    if (a != b || b == f) r = {f, 3'h0};
    else if (c == 3'(FILTER_CYCLES - 1)) r = {b, 3'h0};
    else r = {f, c + 3'h1};
    return r;
  endfunction : filt

  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASED_BYTE;
  end

  assign rd_byte = mem[st.acnt];
  assign dev_match = st.shreg[7:4] == DEV_TYPE_CODE &&
                     st.shreg[3:1] == {st.sel2_s[2], st.sel1_s[2], st.sel0_s[2]};

  always_comb begin
    logic [3:0] fs, fd;
    fs = filt(st.scl_f, st.scl_cnt, st.scl_s[1], st.scl_s[2]);
    fd = filt(st.sda_f, st.sda_cnt, st.sda_s[1], st.sda_s[2]);
    scl_rise = fs[3] & ~st.scl_f;
    scl_fall = ~fs[3] & st.scl_f;
    start_c  = st.scl_f & fs[3] & st.sda_f & ~fd[3];
    stop_c   = st.scl_f & fs[3] & ~st.sda_f & fd[3];
    mem_we   = st.drain & fif.out_valid;
    mem_wa   = st.page_base | ADDR_W'(fif.out_data[FW-1:8]);
    fif.out_ready = st.drain;
    fif.in_valid  = 1'b0;
    fif.in_data   = {st.acnt[OFS_W-1:0], st.shreg};
    flush = 1'b0;

    next_st = st;
    next_st.scl_s  = {st.scl_s[1:0], SCL_I};
    next_st.sda_s  = {st.sda_s[1:0], SDA_I};
    next_st.wp_s   = {st.wp_s[1:0], WP_I};
    next_st.sel0_s = {st.sel0_s[1:0], SELECT_PIN_0_I};
    next_st.sel1_s = {st.sel1_s[1:0], SELECT_PIN_1_I};
    next_st.sel2_s = {st.sel2_s[1:0], SELECT_PIN_2_I};
    {next_st.scl_f, next_st.scl_cnt} = fs;
    {next_st.sda_f, next_st.sda_cnt} = fd;

    // Internal programming: drain buffer, then time out
    if (st.busy) begin
      if (st.drain && !fif.out_valid) next_st.drain = 1'b0;
      if (st.timer == 32'(WRITE_CYC - 1)) next_st.busy = 1'b0;
      else next_st.timer = st.timer + 32'h1;
    end

    if (scl_rise && st.phase != ST_IDLE) begin
      if (st.bitn == BIT_ACK) next_st.nack = fd[3];
      // While sending, the fall shifts the outgoing byte instead
      else if (st.phase != ST_RDAT) next_st.shreg = {st.shreg[6:0], fd[3]};
    end

    if (scl_fall && st.phase != ST_IDLE) begin
      next_st.sda_drv = 1'b0;
      if (st.bitn == 4'h7) begin
        next_st.bitn = BIT_ACK;
        case (st.phase)
          ST_DEV: begin
            next_st.rw = st.shreg[0];
            next_st.sda_drv = dev_match & ~st.busy;
            if (!dev_match || st.busy) next_st.phase = ST_IDLE;
          end
          ST_AHI: begin
            next_st.acnt[ADDR_W-1:8] = st.shreg[ADDR_W-9:0];
            next_st.sda_drv = 1'b1;
          end
          ST_ALO: begin
            next_st.acnt[7:0] = st.shreg;
            next_st.page_base = {st.acnt[ADDR_W-1:8], st.shreg} &
                                ~ADDR_W'(PAGE_BYTES - 1);
            next_st.sda_drv = 1'b1;
          end
          ST_WDAT: begin
            next_st.sda_drv = ~st.wp_lat;
            if (!st.wp_lat) begin
              fif.in_valid = 1'b1;
              next_st.wr_pend = 1'b1;
              next_st.acnt[OFS_W-1:0] = st.acnt[OFS_W-1:0] + 1'b1;
            end else next_st.phase = ST_IDLE;
          end
          default: next_st.sda_drv = 1'b0;
        endcase
      end else if (st.bitn == BIT_ACK) begin
        next_st.bitn = 4'h0;
        case (st.phase)
          ST_DEV: next_st.phase = st.rw ? ST_RDAT : ST_AHI;
          ST_AHI: next_st.phase = ST_ALO;
          ST_ALO: begin
            next_st.phase = ST_WDAT;
            next_st.wp_lat = st.wp_s[2];
          end
          ST_RDAT: begin
            if (st.nack) next_st.phase = ST_IDLE;
            else next_st.acnt = st.acnt + 1'b1;
          end
          default: next_st.phase = st.phase;
        endcase
        if (next_st.phase == ST_RDAT) begin
          next_st.shreg = (st.phase == ST_RDAT) ? mem[st.acnt + 1'b1] : rd_byte;
          next_st.sda_drv = ~((st.phase == ST_RDAT) ? mem[st.acnt + 1'b1][7]
                                                     : rd_byte[7]);
        end
      end else begin
        next_st.bitn = st.bitn + 4'h1;
        if (st.phase == ST_RDAT) begin
          next_st.shreg = {st.shreg[6:0], 1'b1};
          next_st.sda_drv = ~st.shreg[6];
        end
      end
      if (st.phase == ST_RDAT && st.bitn == 4'h7 && !st.nack) next_st.sda_drv = 1'b0;
    end

    if (start_c) begin
      next_st.phase = ST_DEV;
      // The SCL fall that closes START carries no bit
      next_st.bitn = 4'hF;
      next_st.sda_drv = 1'b0;
      next_st.wr_pend = 1'b0;
      flush = ~st.busy;
    end else if (stop_c) begin
      next_st.phase = ST_IDLE;
      next_st.sda_drv = 1'b0;
      if (st.wr_pend) begin
        next_st.busy = 1'b1;
        next_st.drain = 1'b1;
        next_st.timer = 32'h0;
        next_st.wr_pend = 1'b0;
      end
    end
    // Read leaves counter past the last byte; write leaves it after last offset
    if (st.phase == ST_RDAT && next_st.phase == ST_IDLE && !start_c && !stop_c)
      next_st.acnt = st.acnt + 1'b1;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st <= '0;
      st.scl_s <= 3'h7;
      st.sda_s <= 3'h7;
      st.scl_f <= 1'b1;
      st.sda_f <= 1'b1;
      st.phase <= ST_IDLE;
    end else begin
      st <= next_st;
    end
    if (mem_we) mem[mem_wa] <= fif.out_data[7:0];
  end

  eep_fifo #(.WIDTH(FW), .DEPTH(FIFO_D)) u_buf (
    .CLOCK_I (CLOCK_I),
    .RST_I   (RST_I),
    .flush_i (flush),
    .port    (fif)
  );

  assign SDA_O      = 1'b0;
  assign SDA_OE_N_O = ~st.sda_drv;
  assign BUSY_O     = st.busy;
endmodule : eep_slave

/* File: test/eep_slave_assertions.sv */
// Pin-level checks on the serial memory slave
`timescale 1ns/10ps
module eep_chk #(
  parameter int WRITE_CYC = 1000
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic BUSY_O
);
  int   busy_cnt;
  logic seen;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      busy_cnt <= 0;
      seen     <= 1'b0;
    end else begin
      busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;
      if (SCL_I && $fell(SDA_I)) seen <= 1'b1;
    end
  end
  reset_release_a: assert property (disable iff (1'b0)
    RST_I |=> SDA_OE_N_O && !BUSY_O) else $error("active after reset");
  sda_low_a: assert property (SDA_O == 1'b0) else $error("data pin not low");
  drive_edge_a: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
    else $error("drive changed with clock high");
  start_first_a: assert property (!seen |-> SDA_OE_N_O)
    else $error("drive before start");
  busy_cause_a: assert property ($rose(BUSY_O) |-> SCL_I && SDA_I)
    else $error("busy without stop");
  busy_quiet_a: assert property (BUSY_O |-> SDA_OE_N_O)
    else $error("drive while busy");
  busy_len_a: assert property ($fell(BUSY_O) |-> busy_cnt == WRITE_CYC)
    else $error("busy length wrong");
  drive_end_a: assert property ($fell(SDA_OE_N_O) |-> ##[1:1000] $rose(SDA_OE_N_O))
    else $error("drive never released");
  cover property ($rose(BUSY_O));
  cover property ($fell(BUSY_O));
  cover property ($fell(SDA_OE_N_O));
endmodule : eep_chk

bind eep_slave eep_chk #(.WRITE_CYC(WRITE_CYC)) eep_chk_i (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_N_O(SDA_OE_N_O), .BUSY_O(BUSY_O));

/* File: test/eep_master.sv */
// Bus master model; clock idles high between frames
`timescale 1ns/10ps
module eep_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  task automatic start();
    sda_o = 1'b1;
    wt(20);
    scl_o = 1'b1;
    wt(40);
    sda_o = 1'b0;
    wt(40);
    scl_o = 1'b0;
    wt(10);
  endtask : start
  // Data only moves while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    wt(40);
    scl_o = 1'b1;
    wt(40);
    r = sda_i;
    scl_o = 1'b0;
    wt(10);
  endtask : bit_x
  task automatic stop();
    sda_o = 1'b0;
    wt(40);
    scl_o = 1'b1;
    wt(40);
    sda_o = 1'b1;
    wt(60);
  endtask : stop
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!more, r);
  endtask : get_byte
endmodule : eep_master

/* File: test/tb_i2c_serial_eeprom_slave.sv */
// Self-checking bench for the serial memory slave
`timescale 1ns/10ps
module tb_i2c_serial_eeprom_slave;
  import eep_pkg::*;
  logic       clk = 1'b0;
  logic       rst;
  logic       wp;
  logic [2:0] sel;
  logic       scl;
  logic       msda;
  logic       sda;
  logic       dsda;
  logic       oe_n;
  logic       busy;
  int         miscompares = 0;
  int         n_compared = 0;
  int         cyc = 0;
  always #2.5 clk = ~clk;
  // Pulled-up line: low if either party pulls it down
  assign sda = msda & (oe_n | dsda);
  eep_slave #(.WRITE_CYC(2000)) eep_slave_i (.CLOCK_I(clk), .RST_I(rst),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(dsda), .SDA_OE_N_O(oe_n),
    .SELECT_PIN_0_I(sel[0]), .SELECT_PIN_1_I(sel[1]), .SELECT_PIN_2_I(sel[2]),
    .WP_I(wp), .BUSY_O(busy));
  eep_master eep_master_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(msda));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic adr(input logic [15:0] a);
    logic k;
    eep_master_i.start();
    eep_master_i.put_byte({DEV_TYPE_CODE, sel, 1'b0}, k);
    chk("dev ack", 1, k);
    eep_master_i.put_byte(a[15:8], k);
    chk("hi ack", 1, k);
    eep_master_i.put_byte(a[7:0], k);
    chk("lo ack", 1, k);
  endtask : adr
  task automatic wr(input logic [7:0] d);
    logic k;
    eep_master_i.put_byte(d, k);
    chk("data ack", 1, k);
  endtask : wr
  task automatic rd(input logic [7:0] e [$]);
    logic       k;
    logic [7:0] d;
    eep_master_i.start();
    eep_master_i.put_byte({DEV_TYPE_CODE, sel, 1'b1}, k);
    chk("rd ack", 1, k);
    foreach (e[i]) begin
      eep_master_i.get_byte(i < e.size() - 1, d);
      chk("rd data", e[i], d);
    end
    eep_master_i.stop();
    eep_master_i.wt(20);
    chk("busy", 0, busy);
  endtask : rd
  task automatic poll(input logic first);
    logic k;
    k = 1'b0;
    for (int i = 0; i < 10 && !k; i++) begin
      eep_master_i.start();
      eep_master_i.put_byte({DEV_TYPE_CODE, sel, 1'b0}, k);
      eep_master_i.stop();
      if (i == 0 && first) chk("busy nack", 0, k);
    end
    chk("ready", 1, k);
  endtask : poll
  task automatic t_byte();
    adr(16'h0123);
    wr(8'h5A);
    eep_master_i.stop();
    eep_master_i.wt(20);
    chk("busy", 1, busy);
    poll(1'b1);
    adr(16'h0123);
    rd('{8'h5A, 8'hFF});
  endtask : t_byte
  task automatic t_page();
    adr(16'h003E);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    eep_master_i.stop();
    poll(1'b0);
    adr(16'hFFFF);
    rd('{8'hFF, 8'h33});
  endtask : t_page
  task automatic t_wp();
    logic k;
    wp = 1'b1;
    adr(16'h0123);
    eep_master_i.put_byte(8'h77, k);
    chk("wp nack", 0, k);
    eep_master_i.stop();
    wp = 1'b0;
    eep_master_i.wt(20);
    chk("wp busy", 0, busy);
    adr(16'h0123);
    rd('{8'h5A});
  endtask : t_wp
  task automatic t_rst();
    adr(16'h0200);
    wr(8'hC3);
    eep_master_i.stop();
    eep_master_i.wt(20);
    chk("busy", 1, busy);
    rst = 1'b1;
    eep_master_i.wt(12);
    rst = 1'b0;
    eep_master_i.wt(20);
    chk("rst busy", 0, busy);
    chk("rst drive", 1, oe_n);
    poll(1'b0);
  endtask : t_rst
  task automatic t_sel();
    logic k;
    eep_master_i.start();
    eep_master_i.put_byte({DEV_TYPE_CODE, sel ^ 3'h1, 1'b1}, k);
    chk("sel nack", 0, k);
    eep_master_i.stop();
  endtask : t_sel
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      $display("ERROR timeout expected end of tests seen %0d cycles", cyc);
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    sel = 3'h5;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    t_byte();
    t_page();
    t_wp();
    t_rst();
    t_sel();
    summarize();
  end
endmodule : tb_i2c_serial_eeprom_slave
